// ===== hw/sip_pkg.sv
// Constants for the interrupt pulse logic
package sip_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned PULSE_US       = 100;
  localparam int unsigned GAP_US         = 100;
  localparam int unsigned CFG_FILT_US    = 10;
  localparam int unsigned GPIO_FILT_US   = 16;
  localparam int unsigned PULSE_CYC      = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GAP_CYC        = GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CFG_FILT_CYC   = CFG_FILT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GPIO_FILT_CYC  = GPIO_FILT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W          = 13;
  localparam int unsigned WAKE_A_W       = 4;
  localparam int unsigned FAIL_W         = 8;
  localparam int unsigned WA_BUS         = 0;
  localparam int unsigned WA_HVPIN       = 1;
  localparam int unsigned WA_TIMER       = 2;
  localparam int unsigned WA_TIMEOUT     = 3;
  localparam logic [3:0]  WAKE_A_RST     = 4'h0;
  localparam logic [7:0]  FAIL_RST       = 8'h00;
  localparam logic [2:0]  MODE_INIT      = 3'h0;
  localparam logic [2:0]  MODE_NORMAL    = 3'h1;
  localparam logic [2:0]  MODE_STOP      = 3'h2;
  localparam logic [2:0]  MODE_SLEEP     = 3'h3;
  localparam logic [2:0]  MODE_RESTART   = 3'h4;
  localparam logic [2:0]  MODE_FAILSAFE  = 3'h5;
  typedef enum logic [2:0] {
    SIP_IDLE  = 3'b001,
    SIP_PULSE = 3'b010,
    SIP_GAP   = 3'b100
  } sip_state_t;
endpackage

// ===== hw/sip_filter.sv
// Static level filter: output follows input only after it stood stable
`timescale 1ns/1ps
`default_nettype none
module sip_filter #(
  parameter int unsigned CYC = 16
) (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic        sy1_q;
  logic        sy2_q;
  logic [12:0] cnt_q;

  // Pin comes from outside the clock domain
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
    end else begin
      sy1_q <= din_i;
      sy2_q <= sy1_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q  <= 13'h0000;
      dout_o <= 1'b0;
    end else if (sy2_q == dout_o) begin
      cnt_q <= 13'h0000;
    end else if (cnt_q == 13'(CYC - 1)) begin
      cnt_q  <= 13'h0000;
      dout_o <= sy2_q;
    end else begin
      cnt_q <= cnt_q + 13'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== hw/sip_irq.sv
// Interrupt pulse generator with latched wake and failure status
//
// Contract
// - In Normal and Stop, an event drives the pin low for 100 us.
// - Pin stays high at least 100 us between pulses.
// - Pulses never change the operating mode.
// - Class 0 pulses only for latched wake events, register b if pin is wake.
// - A wake event interrupts only if its source is enabled.
// - Bus timeout is a wake source governed only by its own mask.
// - Wake sources: bus wake or timeout, wake pin, timer, general pin.
// - Class 1 adds latched failures; level, identity, selective wake never do.
// - Reset-causing failures, power-on and device state bits never interrupt.
// - No pulse in Restart, Fail-Safe or Sleep.
// - Entering Stop with uncleared wake bits issues a pulse.
// - Host-visible status copies update at each pulse falling edge.
// - Events stay latched until host clears them; level status is not latched.
// - In Init the pin is an input selecting hardware configuration.
// - Configuration level is filtered 10 us before acceptance.
// - Wake pin events always latch in wake status a.
// - General pin wake uses a 16 us filter and latches in wake status b.
`timescale 1ns/1ps
`default_nettype none
module sip_irq (
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       irq_class_global_i,
  input  wire logic       bus_timeout_irq_mask_i,
  input  wire logic       bus_wake_ev_i,
  input  wire logic       bus_timeout_ev_i,
  input  wire logic       timer_wake_ev_i,
  input  wire logic       hv_wake_ev_i,
  input  wire logic       bus_wake_en_i,
  input  wire logic       hv_wake_en_i,
  input  wire logic       timer_wake_en_i,
  input  wire logic       gpio_is_wake_i,
  input  wire logic       gpio_pin_i,
  input  wire logic [7:0] fail_ev_i,
  input  wire logic [3:0] wake_a_clr_i,
  input  wire logic       wake_b_clr_i,
  input  wire logic [7:0] fail_clr_i,
  input  wire logic       irq_pin_i,
  output logic            irq_out_n_o,
  output logic            irq_out_oe_o,
  output logic [3:0]      wake_status_a_o,
  output logic            wake_status_b_o,
  output logic [7:0]      fail_status_o,
  output logic            wake_level_status_o,
  output logic            hw_config_o
);
  sip_pkg::sip_state_t st_q;
  logic [12:0] cnt_q;
  logic [3:0]  wake_a_q;
  logic        wake_b_q;
  logic [7:0]  fail_q;
  logic        pend_q;
  logic        gpio_filt;
  logic        gpio_prev_q;
  logic        cfg_filt;
  logic [2:0]  mode_prev_q;
  logic        irq_mode;
  logic [3:0]  wake_a_set;
  logic        wake_b_set;
  logic        trig;
  logic        stop_entry;

  // Fail inputs carry only status classes allowed to interrupt
  assign irq_mode   = (mode_i == sip_pkg::MODE_NORMAL) || (mode_i == sip_pkg::MODE_STOP);
  assign stop_entry = (mode_i == sip_pkg::MODE_STOP) && (mode_prev_q != sip_pkg::MODE_STOP);

  always_comb begin
    wake_a_set = 4'h0;
    wake_a_set[sip_pkg::WA_BUS]     = bus_wake_ev_i;
    wake_a_set[sip_pkg::WA_HVPIN]   = hv_wake_ev_i;
    wake_a_set[sip_pkg::WA_TIMER]   = timer_wake_ev_i;
    wake_a_set[sip_pkg::WA_TIMEOUT] = bus_timeout_ev_i;
  end
  assign wake_b_set = gpio_is_wake_i && (gpio_filt != gpio_prev_q);

  // Triggering events: class 0 wake only, class 1 adds failures
  assign trig = (bus_wake_ev_i && bus_wake_en_i)
              || (hv_wake_ev_i && hv_wake_en_i)
              || (timer_wake_ev_i && timer_wake_en_i)
              || wake_b_set
              || (bus_timeout_ev_i && !bus_timeout_irq_mask_i)
              || (irq_class_global_i && (|fail_ev_i))
              || (stop_entry && ((|wake_a_q) || wake_b_q));

  sip_filter #(.CYC(sip_pkg::GPIO_FILT_CYC)) u_gpio_filt (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .din_i  (gpio_pin_i),
    .dout_o (gpio_filt)
  );

  sip_filter #(.CYC(sip_pkg::CFG_FILT_CYC)) u_cfg_filt (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .din_i  (irq_pin_i),
    .dout_o (cfg_filt)
  );

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      gpio_prev_q <= 1'b0;
      mode_prev_q <= sip_pkg::MODE_INIT;
    end else begin
      gpio_prev_q <= gpio_filt;
      mode_prev_q <= mode_i;
    end
  end

  // Set wins over clear so no event is lost
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wake_a_q <= sip_pkg::WAKE_A_RST;
      wake_b_q <= 1'b0;
      fail_q   <= sip_pkg::FAIL_RST;
    end else begin
      wake_a_q <= (wake_a_q & ~wake_a_clr_i) | wake_a_set;
      wake_b_q <= (wake_b_q & ~wake_b_clr_i) | wake_b_set;
      fail_q   <= (fail_q & ~fail_clr_i) | fail_ev_i;
    end
  end

  // Mode is only an input here, the pulse logic cannot alter it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q   <= sip_pkg::SIP_IDLE;
      cnt_q  <= 13'h0000;
      pend_q <= 1'b0;
    end else begin
      case (st_q)
        sip_pkg::SIP_IDLE: begin
          if (irq_mode && (trig || pend_q)) begin
            st_q   <= sip_pkg::SIP_PULSE;
            cnt_q  <= 13'h0000;
            pend_q <= 1'b0;
          end else if (!irq_mode) begin
            pend_q <= 1'b0;
          end
        end
        sip_pkg::SIP_PULSE: begin
          if (trig) pend_q <= 1'b1;
          if (cnt_q == 13'(sip_pkg::PULSE_CYC - 1)) begin
            st_q  <= sip_pkg::SIP_GAP;
            cnt_q <= 13'h0000;
          end else begin
            cnt_q <= cnt_q + 13'h0001;
          end
        end
        sip_pkg::SIP_GAP: begin
          if (trig) pend_q <= 1'b1;
          if (cnt_q == 13'(sip_pkg::GAP_CYC - 1)) begin
            st_q  <= sip_pkg::SIP_IDLE;
            cnt_q <= 13'h0000;
          end else begin
            cnt_q <= cnt_q + 13'h0001;
          end
        end
        default: begin
          st_q  <= sip_pkg::SIP_IDLE;
          cnt_q <= 13'h0000;
        end
      endcase
    end
  end

  // Pin released in Init so the strap level can be sensed
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_out_n_o  <= 1'b1;
      irq_out_oe_o <= 1'b0;
    end else begin
      irq_out_n_o  <= !(st_q == sip_pkg::SIP_IDLE && irq_mode && (trig || pend_q))
                      && !(st_q == sip_pkg::SIP_PULSE && cnt_q != 13'(sip_pkg::PULSE_CYC - 1));
      irq_out_oe_o <= (mode_i != sip_pkg::MODE_INIT);
    end
  end

  // Host copies refresh on the pulse falling edge; clears act at once
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wake_status_a_o <= sip_pkg::WAKE_A_RST;
      wake_status_b_o <= 1'b0;
      fail_status_o   <= sip_pkg::FAIL_RST;
    end else if (st_q == sip_pkg::SIP_IDLE && irq_mode && (trig || pend_q)) begin
      wake_status_a_o <= (wake_a_q & ~wake_a_clr_i) | wake_a_set;
      wake_status_b_o <= (wake_b_q & ~wake_b_clr_i) | wake_b_set;
      fail_status_o   <= (fail_q & ~fail_clr_i) | fail_ev_i;
    end else begin
      wake_status_a_o <= wake_status_a_o & ~wake_a_clr_i;
      wake_status_b_o <= wake_status_b_o & ~wake_b_clr_i;
      fail_status_o   <= fail_status_o & ~fail_clr_i;
    end
  end

  // Level status is live, never latched
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wake_level_status_o <= 1'b0;
      hw_config_o         <= 1'b0;
    end else begin
      wake_level_status_o <= gpio_filt;
      if (mode_i == sip_pkg::MODE_INIT) hw_config_o <= cfg_filt;
    end
  end

  logic [12:0] low_cnt_q;
  always_ff @(posedge mclk_i) begin
    if (srst_i) low_cnt_q <= 13'h0000;
    else if (!irq_out_n_o) low_cnt_q <= low_cnt_q + 13'h0001;
    else low_cnt_q <= 13'h0000;
  end

  pulse_width_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(irq_out_n_o) |-> $past(low_cnt_q) == 13'(sip_pkg::PULSE_CYC - 1))
    else $error("Pulse width wrong");
  // Saturates at the gap, so the first pulse after reset counts as spaced
  logic [12:0] high_cnt_q;
  always_ff @(posedge mclk_i) begin
    if (srst_i) high_cnt_q <= 13'(sip_pkg::GAP_CYC);
    else if (!irq_out_n_o) high_cnt_q <= 13'h0000;
    else if (high_cnt_q != 13'(sip_pkg::GAP_CYC)) high_cnt_q <= high_cnt_q + 13'h0001;
  end

  min_gap_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    $fell(irq_out_n_o) |-> $past(high_cnt_q) == 13'(sip_pkg::GAP_CYC))
    else $error("Gap too short");
  quiet_mode_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_q == sip_pkg::SIP_IDLE && !irq_mode) |=> irq_out_n_o)
    else $error("Pulse in quiet mode");
  stop_entry_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (stop_entry && (|wake_a_q) && st_q == sip_pkg::SIP_IDLE) |=> !irq_out_n_o)
    else $error("No pulse on stop entry");
  timeout_mask_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_q == sip_pkg::SIP_IDLE && !pend_q && irq_mode && bus_timeout_irq_mask_i
     && !irq_class_global_i && !(|wake_a_set[2:0]) && !wake_b_set && !stop_entry)
    |=> irq_out_n_o)
    else $error("Masked timeout pulsed");
  latch_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wake_a_q[sip_pkg::WA_HVPIN] && !wake_a_clr_i[sip_pkg::WA_HVPIN])
    |=> wake_a_q[sip_pkg::WA_HVPIN])
    else $error("Wake flag lost");
  hv_latch_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    hv_wake_ev_i |=> wake_a_q[sip_pkg::WA_HVPIN])
    else $error("Wake pin event not latched");
  pending_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (st_q == sip_pkg::SIP_GAP && pend_q && irq_mode && cnt_q == 13'(sip_pkg::GAP_CYC - 1))
    |=> ##1 !irq_out_n_o)
    else $error("Pending event dropped");
  status_copy_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    $fell(irq_out_n_o) |-> wake_status_a_o == $past(wake_a_q & ~wake_a_clr_i | wake_a_set))
    else $error("Status copy not updated");
  init_drive_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (mode_i == sip_pkg::MODE_INIT) |=> !irq_out_oe_o)
    else $error("Pin driven in init");

  pulse_c: cover property (@(posedge mclk_i) disable iff (srst_i) $fell(irq_out_n_o));
  pend_c: cover property (@(posedge mclk_i) disable iff (srst_i) st_q == sip_pkg::SIP_GAP && pend_q);
  stop_c: cover property (@(posedge mclk_i) disable iff (srst_i) stop_entry && (|wake_a_q));
endmodule
`default_nettype wire

// ===== dv/sip_host_model.sv
// Host model: clears latched status after each pulse, then reads it again
`timescale 1ns/1ps
`default_nettype none
module sip_host_model (
  input  wire logic       mclk_i,
  input  wire logic       auto_i,
  input  wire logic       flush_i,
  input  wire logic       irq_n_i,
  input  wire logic [3:0] wake_a_i,
  input  wire logic       wake_b_i,
  input  wire logic [7:0] fail_i,
  output var logic [3:0]  wake_a_clr_o,
  output var logic        wake_b_clr_o,
  output var logic [7:0]  fail_clr_o,
  output var logic        reread_ok_o
);
  logic       irq_q = 1'b1;
  logic [3:0] wait_q = 4'h0;
  logic [1:0] chk_q = 2'h0;
  // One process drives every output; clears go out ten cycles after the fall
  initial begin
    wake_a_clr_o = 4'h0;
    wake_b_clr_o = 1'b0;
    fail_clr_o = 8'h00;
    reread_ok_o = 1'b0;
    forever @(posedge mclk_i) begin
      irq_q <= irq_n_i;
      if (irq_q && !irq_n_i && auto_i) wait_q <= 4'hA;
      else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
      if (flush_i || wait_q == 4'h1) begin
        wake_a_clr_o <= 4'hF;
        wake_b_clr_o <= 1'b1;
        fail_clr_o <= 8'hFF;
        reread_ok_o <= 1'b0;
        chk_q <= 2'h3;
      end else begin
        wake_a_clr_o <= 4'h0;
        wake_b_clr_o <= 1'b0;
        fail_clr_o <= 8'h00;
        if (chk_q != 2'h0) chk_q <= chk_q - 2'h1;
        if (chk_q == 2'h1) reread_ok_o <= (wake_a_i == 4'h0) && !wake_b_i && (fail_i == 8'h00);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/test_sbc_interrupt_pulse_logic.sv
// Self-checking testbench for the interrupt pulse logic
`timescale 1ns/1ps
`default_nettype none
module test_sbc_interrupt_pulse_logic;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [2:0] mode = sip_pkg::MODE_INIT;
  logic [2:0] en = 3'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] fev = 8'h00;
  logic       cls = 0, mask = 0, gp_wake = 0, gp_pin = 0, cfg_lvl = 0, auto = 0, flush = 0;
  logic [3:0] wa_clr, wa;
  logic [7:0] f_clr, fs;
  logic       wb_clr, wb, oe, irq_n, lvl, cfg, ok;
  int         miscompares = 0, tests_run = 0, wc, lc, src, fb;
  sip_irq i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .mode_i(mode), .irq_class_global_i(cls),
    .bus_timeout_irq_mask_i(mask), .bus_wake_ev_i(ev[0]), .bus_timeout_ev_i(ev[1]),
    .timer_wake_ev_i(ev[2]), .hv_wake_ev_i(ev[3]), .bus_wake_en_i(en[0]), .hv_wake_en_i(en[1]),
    .timer_wake_en_i(en[2]), .gpio_is_wake_i(gp_wake), .gpio_pin_i(gp_pin), .fail_ev_i(fev),
    .wake_a_clr_i(wa_clr), .wake_b_clr_i(wb_clr), .fail_clr_i(f_clr),
    .irq_pin_i(oe ? irq_n : cfg_lvl), .irq_out_n_o(irq_n), .irq_out_oe_o(oe),
    .wake_status_a_o(wa), .wake_status_b_o(wb), .fail_status_o(fs),
    .wake_level_status_o(lvl), .hw_config_o(cfg));
  sip_host_model i_host (.mclk_i(mclk_i), .auto_i(auto), .flush_i(flush), .irq_n_i(irq_n),
    .wake_a_i(wa), .wake_b_i(wb), .fail_i(fs), .wake_a_clr_o(wa_clr), .wake_b_clr_o(wb_clr),
    .fail_clr_o(f_clr), .reread_ok_o(ok));
  initial forever #12.5 mclk_i = ~mclk_i;
  // Sources: 0 bus wake, 1 bus timeout, 2 timer, 3 wake pin, 4 failure
  function automatic bit want(input logic [2:0] md, input int s);
    if (md != sip_pkg::MODE_NORMAL && md != sip_pkg::MODE_STOP) return 1'b0;
    case (s)
      0: return en[0];
      1: return !mask;
      2: return en[2];
      3: return en[1];
      default: return cls;
    endcase
  endfunction
  function automatic int copy_bit(input int s);
    return (s == 1) ? 3 : (s == 3) ? 1 : s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic fire(input int s);
    if (s < 4) ev = 4'h1 << s;
    else fev = 8'h01 << fb;
    tick(1);
    ev = 4'h0;
    fev = 8'h00;
  endtask
  task automatic do_flush();
    flush = 1'b1;
    tick(1);
    flush = 1'b0;
    tick(3);
  endtask
  // Bounded waits, so a missing pulse cannot hang the run
  task automatic pulse();
    wc = 0;
    lc = 0;
    while (irq_n !== 1'b0 && wc < 9000) begin tick(1); wc++; end
    while (irq_n === 1'b0 && lc < 5000) begin tick(1); lc++; end
  endtask
  task automatic quiet(input int n);
    lc = 0;
    repeat (n) begin tick(1); if (irq_n !== 1'b1) lc++; end
    check("quiet", lc, 0);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    fork
      begin #(90000 * 25); miscompares++; tally_and_finish(); end
    join_none
    void'($urandom(32'h5055C3B5));
    tick(4);
    srst_i = 1'b0;
    check("rst irq", {oe, irq_n, wa, wb, fs, cfg}, 16'h4000);
    cfg_lvl = 1'b1;
    tick(300);
    check("cfg early", cfg, 0);
    tick(150);
    check("cfg", {oe, cfg}, 1);
    en = 3'h7;
    fire(3);
    quiet(50);
    do_flush();
    mode = sip_pkg::MODE_NORMAL;
    tick(2);
    check("oe normal", oe, 1);
    fire(3);
    fork
      pulse();
      begin tick(100); fire(2); check("copy hv", wa, 4'h2); end
    join
    check("low", {wc[3:0], lc[11:0]}, 16'h0FA0);
    wc = 0;
    while (irq_n === 1'b1 && wc < 9000) begin tick(1); wc++; end
    check("gap", (wc >= 4000 && wc <= 4002), 1);
    pulse();
    check("pend low", {wc[3:0], lc[11:0]}, 16'h0FA0);
    check("copy both", wa, 4'h6);
    tick(4100);
    mode = sip_pkg::MODE_STOP;
    pulse();
    check("stop entry", (wc < 4 && lc == 4000), 1);
    tick(4100);
    do_flush();
    check("cleared", {wa, fs}, 0);
    auto = 1'b1;
    // Every mode but Init visited, other settings random
    for (int t = 0; t < 6; t++) begin
      do_flush();
      mode = 3'(1 + t % 5);
      cls = 1'($urandom);
      mask = 1'($urandom);
      en = 3'($urandom);
      src = $urandom_range(0, 4);
      fb = $urandom_range(0, 7);
      tick(2);
      fire(src);
      if (want(mode, src)) begin
        check("copy", (src < 4) ? wa[copy_bit(src)] : fs[fb], 1);
        pulse();
        check("rnd low", {wc[3:0], lc[11:0]}, 16'h0FA0);
        check("reread", ok, 1);
        tick(4050);
      end else begin
        quiet(60);
      end
    end
    auto = 1'b0;
    do_flush();
    mode = sip_pkg::MODE_NORMAL;
    gp_wake = 1'b1;
    tick(2);
    gp_pin = 1'b1;
    quiet(600);
    check("lvl early", lvl, 0);
    pulse();
    check("gpio", (wc >= 30 && wc <= 50 && lc == 4000), 1);
    check("gpio copy", {wb, lvl}, 2'h3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
